/* File: core/buffer_ram_output_fifo.sv */
// Eight-slot buffer RAM for output sample sets with the 16-bit read port.
// Assumes sample inputs and read pins synchronous to the back-end clock.
// How it works
// - Eight slots, each five 16-bit words: I, Q, magnitude, phase, frequency.
// - Data leaves only when the reader asks for it.
// - Magnitude/phase lag I/Q one sample; frequency lags further by filter delay.
// - Without a new filter output, last frequency value repeats.
// - Config bit 15 selects FIFO mode; bits 14:12 set threshold.
// - Interrupt held low for exactly eight back-end clocks.
// - Depth is write minus read minus one, modulo eight.
// - Parallel port active when bit 24 is one and bit 25 zero.
// - High byte of the chosen word on bus hi, low byte on lo.
// - Select picks word, status or advance.
// - Read pointer advances on select seven at lo enable fall.
// - Both enables read; a new word is fetched on lo enable fall.
// - Status: depth 7:5, empty 4, full 3, ready 2, rest zero.
// - Status bit 2 is active-low ready flag.
// - Write-pointer reset command returns write pointer to zero.
// - Read and write pointers meet only if a read advance coincides with a write-pointer reset.
// - Full at difference seven; no stores while full.
// - Empty at difference one; advances ignored while empty.
// - Reset sets write pointer 0, read pointer 7.
// - In FIFO mode, interrupt fires on a store made while depth sits one below the threshold.
// - Read-advance command moves the read pointer only while the parallel port is off.
`timescale 1ns/1ns
module buffer_ram_output_fifo
    import bufram_pkg::*;
#(
    parameter int FIFO_D = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // Configuration words
    input  wire logic [31:0]          mode_cfg_i,
    input  wire logic [31:0]          route_cfg_i,
    input  wire logic                 wr_ptr_clear_i,
    input  wire logic                 rd_ptr_advance_i,
    input  wire logic                 snapshot_done_i,
    // Sample stream
    input  wire logic                 sample_valid_i,
    output logic                      sample_ready_o,
    input  wire logic [WORD_W-1:0]    in_i_i,
    input  wire logic [WORD_W-1:0]    in_q_i,
    input  wire logic [WORD_W-1:0]    in_mag_i,
    input  wire logic [WORD_W-1:0]    in_phase_i,
    input  wire logic [WORD_W-1:0]    in_freq_i,
    input  wire logic                 freq_new_i,
    // Parallel read port
    input  wire logic [2:0]           sel_i,
    input  wire logic                 hi_bus_read_enable_n_i,
    input  wire logic                 lo_bus_read_enable_n_i,
    output logic [7:0]                output_bus_hi_o,
    output logic [7:0]                output_bus_lo_o,
    output logic                      output_bus_en_o,
    // Interrupt
    output logic                      buffer_irq_n_o
);
    import bufram_pkg::*;

    typedef struct packed {
        logic [PTR_W-1:0]  wp;
        logic [PTR_W-1:0]  rp;
        logic [WORD_W-1:0] mag_d;
        logic [WORD_W-1:0] ph_d;
        logic [WORD_W-1:0] freq_hold;
        logic [FREQ_LAG*WORD_W-1:0] freq_line;
        logic              lo_en_d;
        logic [WORD_W-1:0] word_out;
        logic [3:0]        irq_cnt;
    } core_state_t;

    core_state_t      st_reg;
    core_state_t      st_next;
    logic [SET_W-1:0] ram [SLOT_COUNT];
    logic [SET_W-1:0] q_set;
    logic             q_valid;
    logic             q_pop;
    logic [PTR_W-1:0] depth;
    logic             full;
    logic             empty;
    logic             fifo_mode;
    logic [2:0]       thresh;
    logic             par_on;
    logic             lo_fall;
    logic             ready_flag;
    logic [WORD_W-1:0] status_word;
    logic [SET_W-1:0] set_in;
    logic             do_write;

    // ---------------------------------------------------------------
    // Alignment of the incoming set
    // ---------------------------------------------------------------
    // Mag/phase held one sample so they trail the I/Q stored beside them
    assign set_in = {in_i_i, in_q_i, st_reg.mag_d, st_reg.ph_d,
                     st_reg.freq_line[FREQ_LAG*WORD_W-1 -: WORD_W]};

    sample_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_in_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .in_data_i   (set_in),
        .out_valid_o (q_valid),
        .out_ready_i (q_pop),
        .out_data_o  (q_set)
    );

    // ---------------------------------------------------------------
    // Configuration and flags
    // ---------------------------------------------------------------
    assign fifo_mode  = mode_cfg_i[FIFO_MODE_BIT];
    assign thresh     = mode_cfg_i[THRESH_LSB +: THRESH_W];
    assign par_on     = route_cfg_i[PAR_SEL_BIT] && !route_cfg_i[PAR_BLOCK_BIT];
    assign depth      = st_reg.wp - st_reg.rp - 3'h1;
    assign full       = (st_reg.wp - st_reg.rp) == FULL_DIFF;
    assign empty      = (st_reg.wp - st_reg.rp) == EMPTY_DIFF;
    assign ready_flag = fifo_mode ? !(depth >= thresh) : !snapshot_done_i;
    assign lo_fall    = st_reg.lo_en_d && !lo_bus_read_enable_n_i;
    // Drain the queue only when a slot is free; full stalls the source
    assign q_pop      = q_valid && !full;
    assign do_write   = q_pop;

    assign status_word = {8'(depth) << ST_DEPTH_LSB
                          | 8'(empty) << ST_EMPTY_BIT
                          | 8'(full) << ST_FULL_BIT
                          | 8'(ready_flag) << ST_READY_BIT,
                          8'h00};

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.lo_en_d = lo_bus_read_enable_n_i;
        if (sample_valid_i && sample_ready_o) begin
            st_next.mag_d = in_mag_i;
            st_next.ph_d  = in_phase_i;
            if (freq_new_i) begin
                st_next.freq_hold = in_freq_i;
            end
            st_next.freq_line = {st_reg.freq_line[(FREQ_LAG-1)*WORD_W-1:0],
                                 freq_new_i ? in_freq_i : st_reg.freq_hold};
        end
        if (do_write) begin
            st_next.wp = st_reg.wp + 3'h1;
        end
        if (wr_ptr_clear_i) begin
            // Keep pointers apart: read lands just below slot zero
            st_next.wp = WR_PTR_RST;
            st_next.rp = RD_PTR_RST;
        end
        if (!empty && ((par_on && lo_fall && sel_i == SEL_ADVANCE)
                       || (!par_on && rd_ptr_advance_i))) begin
            st_next.rp = st_reg.rp + 3'h1;
        end
        if (par_on && lo_fall) begin
            unique case (sel_i)
                SEL_I:       st_next.word_out = ram[st_reg.rp][79:64];
                SEL_Q:       st_next.word_out = ram[st_reg.rp][63:48];
                SEL_MAG:     st_next.word_out = ram[st_reg.rp][47:32];
                SEL_PHASE:   st_next.word_out = ram[st_reg.rp][31:16];
                SEL_FREQ:    st_next.word_out = ram[st_reg.rp][15:0];
                SEL_UNUSED:  st_next.word_out = 16'h0000;
                SEL_STATUS:  st_next.word_out = status_word;
                SEL_ADVANCE: st_next.word_out = 16'h0000;
            endcase
        end
        // Edge on depth, so a level sitting at threshold gives one pulse
        if (fifo_mode && do_write && depth + 3'h1 == thresh
            && st_reg.irq_cnt == 4'h0) begin
            st_next.irq_cnt = 4'(IRQ_CYCLES);
        end else if (st_reg.irq_cnt != 4'h0) begin
            st_next.irq_cnt = st_reg.irq_cnt - 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // Registers and slot memory
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg    <= '0;
            st_reg.wp <= WR_PTR_RST;
            st_reg.rp <= RD_PTR_RST;
            st_reg.lo_en_d <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
        if (do_write) begin
            ram[st_reg.wp] <= q_set;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign output_bus_hi_o = st_reg.word_out[15:8];
    assign output_bus_lo_o = st_reg.word_out[7:0];
    assign output_bus_en_o = par_on && !hi_bus_read_enable_n_i
                             && !lo_bus_read_enable_n_i;
    assign buffer_irq_n_o  = (st_reg.irq_cnt == 4'h0);
endmodule

/* File: core/bufram_pkg.sv */
// Constants for the buffer RAM output port.
// Assumes one back-end clock domain, synchronous active-low reset.
package bufram_pkg;
    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int         SLOT_COUNT     = 8;
    localparam int         PTR_W          = 3;
    localparam int         WORD_W         = 16;
    localparam int         SET_W          = 80;
    localparam int         FIFO_DEPTH     = 16;
    localparam int         FIFO_W         = 80;
    // ---------------------------------------------------------------
    // Pointer reset values and full/empty differences
    // ---------------------------------------------------------------
    localparam logic [2:0] WR_PTR_RST     = 3'h0;
    localparam logic [2:0] RD_PTR_RST     = 3'h7;
    localparam logic [2:0] FULL_DIFF      = 3'h7;
    localparam logic [2:0] EMPTY_DIFF     = 3'h1;
    // ---------------------------------------------------------------
    // Configuration field positions
    // ---------------------------------------------------------------
    localparam int         FIFO_MODE_BIT  = 15;
    localparam int         THRESH_LSB     = 12;
    localparam int         THRESH_W       = 3;
    localparam int         PAR_SEL_BIT    = 24;
    localparam int         PAR_BLOCK_BIT  = 25;
    // ---------------------------------------------------------------
    // Output select codes
    // ---------------------------------------------------------------
    localparam logic [2:0] SEL_I          = 3'h0;
    localparam logic [2:0] SEL_Q          = 3'h1;
    localparam logic [2:0] SEL_MAG        = 3'h2;
    localparam logic [2:0] SEL_PHASE      = 3'h3;
    localparam logic [2:0] SEL_FREQ       = 3'h4;
    localparam logic [2:0] SEL_UNUSED     = 3'h5;
    localparam logic [2:0] SEL_STATUS     = 3'h6;
    localparam logic [2:0] SEL_ADVANCE    = 3'h7;
    localparam logic [3:0] STATUS_OFFSET  = 4'h6;
    // ---------------------------------------------------------------
    // Status word field positions (hi byte)
    // ---------------------------------------------------------------
    localparam int         ST_DEPTH_LSB   = 5;
    localparam int         ST_EMPTY_BIT   = 4;
    localparam int         ST_FULL_BIT    = 3;
    localparam int         ST_READY_BIT   = 2;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int         CLK_PERIOD_NS  = 20;
    localparam int         IRQ_CYCLES     = 8;
    localparam int         SETTLE_CYCLES  = 4;
    localparam int         FREQ_TAPS      = 63;
    localparam int         FREQ_LAG       = FREQ_TAPS - 1;
endpackage

/* File: core/sample_fifo.sv */
// Valid/ready FIFO of parameterised width and depth.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ns
module sample_fifo #(
    parameter int W = 80,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_state_t;
    fifo_state_t  st_reg;
    fifo_state_t  st_next;
    logic [W-1:0] mem [D];
    logic         push;
    logic         pop;

    assign in_ready_o  = (st_reg.cnt != (AW+1)'(D));
    assign out_valid_o = (st_reg.cnt != '0);
    assign out_data_o  = mem[st_reg.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
        if (push) begin
            mem[st_reg.wp] <= in_data_i;
        end
    end
endmodule

/* File: dv/bufram_port_checker_assertions.sv */
// Checker for the buffer RAM read port, status word and interrupt.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module bufram_port_checker
    import bufram_pkg::*;
#(
    parameter int FIFO_D = 16
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // Configuration
    input wire logic [31:0] mode_cfg_i,
    input wire logic [31:0] route_cfg_i,
    input wire logic        snapshot_done_i,
    // Read port
    input wire logic [2:0]  sel_i,
    input wire logic        hi_bus_read_enable_n_i,
    input wire logic        lo_bus_read_enable_n_i,
    input wire logic [7:0]  output_bus_hi_o,
    input wire logic [7:0]  output_bus_lo_o,
    input wire logic        output_bus_en_o,
    // Interrupt
    input wire logic        buffer_irq_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic       lo_q;
    wire        port_on = route_cfg_i[PAR_SEL_BIT] && !route_cfg_i[PAR_BLOCK_BIT];
    wire        fall    = port_on && !lo_bus_read_enable_n_i && lo_q;
    wire        st_rd   = fall && (sel_i == SEL_STATUS);
    wire        fifo_md = mode_cfg_i[FIFO_MODE_BIT];
    wire  [2:0] dep     = output_bus_hi_o[7:5];
    always_ff @(posedge clk_i) begin
        lo_q <= lo_bus_read_enable_n_i;
    end
    AST_IRQ_LEN: assert property (
        $fell(buffer_irq_n_o) |-> !buffer_irq_n_o [*8] ##1 buffer_irq_n_o)
        else $error("irq low time wrong");
    AST_EN_DECODE: assert property (
        output_bus_en_o == (port_on && !hi_bus_read_enable_n_i && !lo_bus_read_enable_n_i))
        else $error("bus enable decode wrong");
    AST_BYTES_HOLD: assert property (
        $changed({output_bus_hi_o, output_bus_lo_o}) |-> $past(fall))
        else $error("bytes changed without a read");
    AST_STATUS_ZERO: assert property (
        st_rd |=> output_bus_lo_o == 8'h00 && output_bus_hi_o[1:0] == 2'h0)
        else $error("status zero bits set");
    AST_FLAGS: assert property (
        st_rd && fifo_md |=> output_bus_hi_o[4] == (dep == 3'h0) && output_bus_hi_o[3] == (dep == 3'h6))
        else $error("empty or full flag disagrees with depth");
    AST_PTR_APART: assert property (
        st_rd && fifo_md |=> dep != 3'h7)
        else $error("pointers met");
    AST_READY_FIFO: assert property (
        st_rd && fifo_md |=> output_bus_hi_o[2] == (dep < $past(mode_cfg_i[14:12])))
        else $error("ready flag disagrees with threshold");
    AST_READY_SNAP: assert property (
        st_rd && !fifo_md |=> output_bus_hi_o[2] == !$past(snapshot_done_i))
        else $error("snapshot ready flag wrong");
endmodule
bind buffer_ram_output_fifo bufram_port_checker #(.FIFO_D(FIFO_D)) chk (
    .clk_i, .rst_n_i, .mode_cfg_i, .route_cfg_i, .snapshot_done_i, .sel_i,
    .hi_bus_read_enable_n_i, .lo_bus_read_enable_n_i, .output_bus_hi_o,
    .output_bus_lo_o, .output_bus_en_o, .buffer_irq_n_o);

/* File: dv/port_reader.sv */
// Reader model: the 16-bit processor on the buffer read port.
// Assumes the bench calls its tasks at a falling clock edge.
`timescale 1ns/1ns
module port_reader (
    // Clock
    input  wire logic       clk_i,
    // Read pins
    output logic [2:0]      sel_o,
    output logic            hi_en_n_o,
    output logic            lo_en_n_o,
    // Returned bytes
    input  wire logic [7:0] hi_i,
    input  wire logic [7:0] lo_i
);
    initial begin
        sel_o = 3'h0;
        hi_en_n_o = 1'b1;
        lo_en_n_o = 1'b1;
    end
    // Both enables low; held through the answer edge
    task automatic rd(input logic [2:0] s, output logic [15:0] w);
        @(negedge clk_i);
        sel_o = s;
        hi_en_n_o = 1'b0;
        lo_en_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        w = {hi_i, lo_i};
        hi_en_n_o = 1'b1;
        lo_en_n_o = 1'b1;
    endtask
    // Advance first, then settle before any read
    task automatic adv();
        logic [15:0] d;
        rd(3'h7, d);
        repeat (4) @(negedge clk_i);
    endtask
endmodule

/* File: dv/buffer_ram_output_fifo_tb_top.sv */
// Testbench: sample sets in, 16-bit port reads and status checks out.
// Assumes the reader model and the bound checker.
`timescale 1ns/1ns
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, a); end end
module buffer_ram_output_fifo_tb_top;
    import bufram_pkg::*;
    logic clk_i, rst_n_i, wr_ptr_clear_i, rd_ptr_advance_i, snapshot_done_i;
    logic sample_valid_i, sample_ready_o, freq_new_i, output_bus_en_o, buffer_irq_n_o;
    logic hi_bus_read_enable_n_i, lo_bus_read_enable_n_i;
    logic [31:0] mode_cfg_i, route_cfg_i;
    logic [15:0] in_i_i, in_q_i, in_mag_i, in_phase_i, in_freq_i, w;
    logic [7:0]  output_bus_hi_o, output_bus_lo_o;
    logic [2:0]  sel_i;
    int n_fail = 0, check_count = 0, irq_cyc = 0, nxt = 0;
    buffer_ram_output_fifo #(.FIFO_D(16)) uut (.clk_i, .rst_n_i, .mode_cfg_i, .route_cfg_i,
        .wr_ptr_clear_i, .rd_ptr_advance_i, .snapshot_done_i, .sample_valid_i,
        .sample_ready_o, .in_i_i, .in_q_i, .in_mag_i, .in_phase_i, .in_freq_i, .freq_new_i,
        .sel_i, .hi_bus_read_enable_n_i, .lo_bus_read_enable_n_i, .output_bus_hi_o,
        .output_bus_lo_o, .output_bus_en_o, .buffer_irq_n_o);
    port_reader rdr (.clk_i, .sel_o(sel_i), .hi_en_n_o(hi_bus_read_enable_n_i),
        .lo_en_n_o(lo_bus_read_enable_n_i), .hi_i(output_bus_hi_o), .lo_i(output_bus_lo_o));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(negedge clk_i) if (buffer_irq_n_o === 1'b0) irq_cyc++;
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Valid held high across sets, so it never toggles twice in one step
    task automatic push(input int n);
        int k;
        repeat (n) begin
            in_i_i = 16'h1000 + 16'(nxt);
            in_q_i = 16'h3000 + 16'(nxt);
            in_mag_i = 16'h2000 + 16'(nxt);
            in_freq_i = 16'h4000 + 16'(nxt);
            freq_new_i = nxt[0];
            sample_valid_i = 1'b1;
            for (k = 0; k < 40 && !sample_ready_o; k++) @(negedge clk_i);
            @(negedge clk_i);
            nxt++;
        end
        sample_valid_i = 1'b0;
        repeat (8) @(negedge clk_i);
    endtask
    task automatic stat(input logic [7:0] e);
        rdr.rd(SEL_STATUS, w);
        `CHK("status", {e, 8'h00}, w)
    endtask
    task automatic rset(input int n);
        rdr.adv();
        rdr.rd(SEL_I, w);
        `CHK("i word", 16'h1000 + 16'(n), w)
        rdr.rd(SEL_Q, w);
        `CHK("q word", 16'h3000 + 16'(n), w)
        rdr.rd(SEL_MAG, w);
        if (n > 0) `CHK("mag word", 16'h1fff + 16'(n), w)
        // Under 62 sets pushed in all, so the delayed frequency is still zero
        rdr.rd(SEL_FREQ, w);
        `CHK("freq word", 16'h0000, w)
    endtask
    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        {wr_ptr_clear_i, rd_ptr_advance_i, snapshot_done_i, sample_valid_i} = 4'h0;
        {in_i_i, in_q_i, in_mag_i, in_freq_i, freq_new_i} = '0;
        in_phase_i = 16'h5a5a;
        mode_cfg_i = 32'h0000_b000;
        route_cfg_i = 32'h0100_0000;
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        stat(8'h14);
        rdr.adv();
        stat(8'h14);
        $display("test reset done");
        push(2);
        stat(8'h44);
        push(1);
        stat(8'h60);
        repeat (8) @(negedge clk_i);
        `CHK("irq cycles", 8, irq_cyc)
        $display("test threshold done");
        for (int n = 0; n < 3; n++) rset(n);
        stat(8'h14);
        rdr.adv();
        rdr.rd(SEL_I, w);
        `CHK("i after refused advance", 16'h1002, w)
        $display("test read done");
        push(22);
        `CHK("sample ready", 1'b0, sample_ready_o)
        stat(8'hc8);
        for (int n = 3; n < 25; n++) rset(n);
        stat(8'h14);
        `CHK("irq cycles", 16, irq_cyc)
        $display("test full done");
        push(2);
        route_cfg_i = 32'h0300_0000;
        rdr.rd(SEL_I, w);
        `CHK("bytes while port off", 16'h1400, w)
        rd_ptr_advance_i = 1'b1;
        @(negedge clk_i);
        rd_ptr_advance_i = 1'b0;
        repeat (4) @(negedge clk_i);
        route_cfg_i = 32'h0100_0000;
        stat(8'h24);
        wr_ptr_clear_i = 1'b1;
        @(negedge clk_i);
        wr_ptr_clear_i = 1'b0;
        stat(8'h14);
        push(1);
        rset(27);
        $display("test commands done");
        mode_cfg_i = 32'h0000_3000;
        snapshot_done_i = 1'b1;
        rdr.rd(SEL_STATUS, w);
        `CHK("ready flag", 1'b0, w[10])
        snapshot_done_i = 1'b0;
        rdr.rd(SEL_STATUS, w);
        `CHK("ready flag", 1'b1, w[10])
        $display("test snapshot done");
        end_sim();
    end
    // Far beyond the roughly 640 cycles the sequence needs
    initial begin
        #(CLK_PERIOD_NS * 5000);
        n_fail++;
        end_sim();
    end
endmodule
